// ### dv/fpsb_flash_model.sv
`timescale 1ns/1ps
module fpsb_flash_model (
    // Flash pins.
    input wire logic [20:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_n_i,
    input wire logic rd_n_i,
    output logic [15:0] rdata_o
);
    logic [15:0] mem_r [16];
    logic [15:0] q_r = 16'h0000;
    logic [7:0] tgt_r = 8'h00;
    logic arm_r = 1'b0, tog_r = 1'b0, err_r = 1'b0, ers_r = 1'b0;
    int busy_r = 0;
    initial foreach (mem_r[i]) mem_r[i] = 16'hFFFF;
    // A released bus shows the inverse of the last word, never a stale copy.
    assign rdata_o = rd_n_i ? ~q_r : q_r;
    always @(posedge wr_n_i) begin
        if (arm_r) begin
            arm_r = 1'b0;
            tgt_r = wdata_i[7:0];
            err_r = |(wdata_i & ~mem_r[addr_i[4:1]]);
            mem_r[addr_i[4:1]] = mem_r[addr_i[4:1]] & wdata_i;
            busy_r = 3;
        end else if (wdata_i[7:0] == 8'hA0) begin
            arm_r = 1'b1;
        end else if (wdata_i[7:0] == 8'h30 || wdata_i[7:0] == 8'h10) begin
            ers_r = 1'b1;
            busy_r = 4;
        end else if (wdata_i[7:0] == 8'hF0) begin
            err_r = 1'b0;
            busy_r = 0;
        end
    end
    always @(negedge rd_n_i) begin
        if (busy_r > 0 || err_r) begin
            tog_r = ~tog_r;
            q_r = {8'h00, ~ers_r & ~tgt_r[7], tog_r, err_r, 1'b0, ers_r, 3'h0};
            if (!err_r) busy_r--;
            if (busy_r == 0 && ers_r) begin
                ers_r = 1'b0;
                foreach (mem_r[i]) mem_r[i] = 16'hFFFF;
            end
        end else q_r = mem_r[addr_i[4:1]];
    end
endmodule // fpsb_flash_model

// ### dv/fpsb_host_assertions.sv
`timescale 1ns/1ps
module fpsb_host_checker #(
    parameter int ADDR_W = 21
) (
    // Watched ports.
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic [ADDR_W-1:0] flash_addr_o,
    input wire logic [15:0] flash_dq_o,
    input wire logic flash_dq_oe_o,
    input wire logic flash_wr_n_o,
    input wire logic flash_rd_n_o,
    input wire logic [7:0] main_sector_select_o,
    input wire logic [3:0] boot_sector_select_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_strobe_excl: assert property (flash_wr_n_o || flash_rd_n_o)
        else $error("both flash strobes low");
    chk_oe_on_write: assert property (!flash_wr_n_o |-> flash_dq_oe_o)
        else $error("write strobe without data drive");
    chk_no_oe_read: assert property (!flash_rd_n_o |-> !flash_dq_oe_o)
        else $error("data driven during read");
    chk_write_len: assert property ($fell(flash_wr_n_o) |=> !flash_wr_n_o ##1 flash_wr_n_o)
        else $error("write pulse length wrong");
    chk_read_len: assert property ($fell(flash_rd_n_o) |=> !flash_rd_n_o [*3] ##1 flash_rd_n_o)
        else $error("read pulse length wrong");
    chk_write_hold: assert property (!flash_wr_n_o && $past(flash_wr_n_o) == 1'b0
        |-> $stable(flash_addr_o) && $stable(flash_dq_o)) else $error("write cycle not held");
    chk_unlock_addr: assert property ($fell(flash_wr_n_o) && flash_dq_o == 16'h0055
        |-> flash_addr_o[11:0] == 12'h554) else $error("second unlock at wrong offset");
    chk_rdata_hold: assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o))
        else $error("read data moved without read");
    chk_read_select: assert property (!flash_rd_n_o |-> main_sector_select_o != 8'h00)
        else $error("read without sector select");
    chk_select_drop: assert property ($rose(flash_wr_n_o) || $rose(flash_rd_n_o)
        |=> main_sector_select_o == 8'h00 && boot_sector_select_o == 4'h0)
        else $error("sector selects held after bus cycle");
    cover property ($fell(flash_wr_n_o));
    cover property ($fell(flash_rd_n_o));
    cover property (reg_rd_i);
endmodule // fpsb_host_checker
bind fpsb_host fpsb_host_checker #(.ADDR_W(ADDR_W)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .flash_addr_o(flash_addr_o), .flash_dq_o(flash_dq_o),
    .flash_dq_oe_o(flash_dq_oe_o), .flash_wr_n_o(flash_wr_n_o), .flash_rd_n_o(flash_rd_n_o),
    .main_sector_select_o(main_sector_select_o), .boot_sector_select_o(boot_sector_select_o));

// ### dv/fpsb_host_bench.sv
`timescale 1ns/1ps
module fpsb_host_bench;
    import fpsb_pkg::*;
    typedef struct {logic en; logic [31:0] mask; logic [31:0] exp;} fpsb_note_t;
    logic clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, rd_d = 1'b0;
    logic [4:0] reg_addr_i = 5'h00;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
    logic [20:0] flash_addr_o;
    logic [15:0] flash_dq_o, flash_dq_i, d;
    logic flash_dq_oe_o, flash_wr_n_o, flash_rd_n_o;
    logic [7:0] main_sector_select_o;
    logic [3:0] boot_sector_select_o;
    int mismatches = 0, n_compared = 0;
    fpsb_note_t notes[$];
    fpsb_note_t note;
    always #25 clk_i = ~clk_i;
    fpsb_host #(.ADDR_W(21), .POLL_MAX(8)) dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .flash_addr_o(flash_addr_o), .flash_dq_o(flash_dq_o), .flash_dq_oe_o(flash_dq_oe_o),
        .flash_dq_i(flash_dq_i), .flash_wr_n_o(flash_wr_n_o), .flash_rd_n_o(flash_rd_n_o),
        .main_sector_select_o(main_sector_select_o), .boot_sector_select_o(boot_sector_select_o));
    fpsb_flash_model flash (.addr_i(flash_addr_o), .wdata_i(flash_dq_o), .wr_n_i(flash_wr_n_o),
        .rd_n_i(flash_rd_n_o), .rdata_o(flash_dq_i));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD reg_rdata_o expected %h seen %h", exp, seen);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic en, input logic [31:0] m, input logic [31:0] e);
        notes.push_back('{en, m, e});
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
    endtask
    // Issues one order and polls the busy flag until it drops.
    task automatic run(input logic [31:0] c);
        wr(REG_CTRL, c);
        for (int i = 0; i < 3000; i++) begin
            rd(REG_STATUS, 1'b0, 32'h0, 32'h0);
            #1;
            if (reg_rdata_o[0] === 1'b0) break;
        end
        check({31'h0, reg_rdata_o[0]}, 32'h0);
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk_i) begin
        rd_d <= reg_rd_i;
        if (rd_d && notes.size() > 0) begin
            note = notes.pop_front();
            if (note.en) check(reg_rdata_o & note.mask, note.exp);
        end
    end
    initial begin
        #3000000;
        mismatches++;
        final_report();
    end
    initial begin
        void'($urandom(27210));
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(REG_STATUS, 1'b1, 32'hFF, 32'h00);
        rd(5'h18, 1'b1, 32'hFFFFFFFF, 32'h0);
        wr(REG_SELECT, 32'h101);
        rd(REG_SELECT, 1'b1, 32'hFFF, 32'h101);
        wr(REG_ADDR, 32'h0);
        run(32'(CMD_SERASE));
        rd(REG_STATUS, 1'b1, 32'hFF, 32'h02);
        for (int i = 0; i < 4; i++) begin
            d = 16'($urandom) & 16'hFFFE;
            wr(REG_ADDR, 32'(2 * i));
            wr(REG_DATA, {16'h0, d});
            run(32'(CMD_PROG) | (32'(i % 2) << CTRL_TOGGLE_BIT));
            rd(REG_STATUS, 1'b1, 32'hFF, 32'h02);
            rd(REG_RDATA, 1'b1, 32'hFFFF, {16'h0, d});
        end
        wr(REG_DATA, {16'h0, ~d});
        run(32'(CMD_PROG));
        rd(REG_STATUS, 1'b1, 32'h2084, 32'h2084);
        run(32'(CMD_PROG));
        rd(REG_STATUS, 1'b1, 32'h10, 32'h10);
        run(32'(CMD_RESET));
        rd(REG_STATUS, 1'b1, 32'h80, 32'h00);
        run(32'(CMD_BYP_ENTER));
        rd(REG_STATUS, 1'b1, 32'h40, 32'h40);
        wr(REG_ADDR, 32'h8);
        wr(REG_DATA, {16'h0, d});
        run(32'(CMD_BYP_PROG));
        rd(REG_RDATA, 1'b1, 32'hFFFF, {16'h0, d});
        run(32'(CMD_SERASE));
        rd(REG_STATUS, 1'b1, 32'h50, 32'h50);
        run(32'(CMD_BYP_EXIT));
        rd(REG_STATUS, 1'b1, 32'h40, 32'h00);
        run(32'(CMD_READ));
        rd(REG_RDATA, 1'b1, 32'hFFFF, {16'h0, d});
        run(32'(CMD_BERASE) | (32'h1 << CTRL_TOGGLE_BIT));
        rd(REG_STATUS, 1'b1, 32'hFF, 32'h02);
        run(32'(CMD_READ));
        rd(REG_RDATA, 1'b1, 32'hFFFF, 32'hFFFF);
        final_report();
    end
endmodule // fpsb_host_bench

// ### hdl/fpsb_bus.sv
`timescale 1ns/1ps
module fpsb_bus
    import fpsb_pkg::*;
#(
    parameter int ADDR_W = 21
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Cycle request.
    input wire logic start_i,
    input wire logic write_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic [11:0] sel_i,
    output logic done_o,
    output logic [15:0] rdata_o,
    // Flash pins.
    output logic [ADDR_W-1:0] flash_addr_o,
    output logic [15:0] flash_dq_o,
    output logic flash_dq_oe_o,
    input wire logic [15:0] flash_dq_i,
    output logic flash_wr_n_o,
    output logic flash_rd_n_o,
    output logic [7:0] main_sector_select_o,
    output logic [3:0] boot_sector_select_o
);
    typedef enum logic [1:0] {B_IDLE, B_SETUP, B_STROBE, B_HOLD} fpsb_bst_t;
    fpsb_bst_t state_r;
    logic [7:0] cnt_r;
    logic write_r;
    logic [15:0] dq_meta_r;
    logic [15:0] dq_sync_r;

    if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr_w
        $error("fpsb_bus: ADDR_W must be 12 to 32");
    end

    always_ff @(posedge clk_i) begin
        dq_meta_r <= flash_dq_i;
        dq_sync_r <= dq_meta_r;
    end

    // A read strobe stays low long enough for the data to pass the synchroniser.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= B_IDLE;
            cnt_r <= 8'h00;
            write_r <= 1'b0;
        end else begin
            unique case (state_r)
                B_IDLE: begin
                    if (start_i) begin
                        state_r <= B_SETUP;
                        write_r <= write_i;
                    end
                end
                B_SETUP: begin
                    state_r <= B_STROBE;
                    cnt_r <= write_r ? 8'(STROBE_CYC - 1) : 8'(STROBE_CYC + SYNC_CYC - 1);
                end
                B_STROBE: begin
                    if (cnt_r == 8'h00) begin
                        state_r <= B_HOLD;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                B_HOLD: state_r <= B_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flash_addr_o <= '0;
            flash_dq_o <= 16'h0000;
            flash_dq_oe_o <= 1'b0;
            main_sector_select_o <= 8'h00;
            boot_sector_select_o <= 4'h0;
        end else if (state_r == B_IDLE && start_i) begin
            flash_addr_o <= addr_i;
            flash_dq_o <= wdata_i;
            flash_dq_oe_o <= write_i;
            main_sector_select_o <= sel_i[7:0];
            boot_sector_select_o <= sel_i[11:8];
        end else if (state_r == B_HOLD) begin
            flash_dq_oe_o <= 1'b0;
            main_sector_select_o <= 8'h00;
            boot_sector_select_o <= 4'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flash_wr_n_o <= 1'b1;
            flash_rd_n_o <= 1'b1;
            rdata_o <= 16'h0000;
        end else begin
            flash_wr_n_o <= !(state_r == B_SETUP && write_r) && !(state_r == B_STROBE && write_r && cnt_r != 8'h00);
            flash_rd_n_o <= !(state_r == B_SETUP && !write_r) && !(state_r == B_STROBE && !write_r && cnt_r != 8'h00);
            if (state_r == B_STROBE && cnt_r == 8'h00 && !write_r) begin
                rdata_o <= dq_sync_r;
            end
        end
    end

    assign done_o = (state_r == B_HOLD);
endmodule // fpsb_bus

// ### hdl/fpsb_host.sv
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps
module fpsb_host
    import fpsb_pkg::*;
#(
    parameter int ADDR_W = 21,
    parameter int POLL_MAX = POLL_MAX_DEF
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Software register port.
    input wire logic [4:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Flash pins.
    output logic [ADDR_W-1:0] flash_addr_o,
    output logic [15:0] flash_dq_o,
    output logic flash_dq_oe_o,
    input wire logic [15:0] flash_dq_i,
    output logic flash_wr_n_o,
    output logic flash_rd_n_o,
    output logic [7:0] main_sector_select_o,
    output logic [3:0] boot_sector_select_o
);
    typedef enum logic [2:0] {S_IDLE, S_WRITE, S_POLL, S_VERIFY, S_READ, S_WAIT} fpsb_st_t;
    fpsb_st_t state_r;
    logic [3:0] cmd_r;
    logic toggle_mode_r;
    logic [ADDR_W-1:0] tgt_addr_r;
    logic [15:0] tgt_data_r;
    logic [11:0] select_r;
    logic [2:0] step_r;
    logic pend_r;
    logic bypass_r;
    logic err_seen_r;
    logic busy_r, done_r, fail_r, verify_err_r, refused_r, tmo_r;
    logic have_prev_r, recheck_r;
    logic [15:0] prev_r;
    logic [15:0] last_rd_r;
    logic [15:0] poll_cnt_r;
    logic [9:0] wait_cnt_r;
    logic bus_start, bus_done;
    logic [15:0] bus_rdata;
    fpsb_step_t step;
    logic start_ok;
    logic [3:0] new_cmd;
    logic poll_hit;

    if (POLL_MAX < 1 || POLL_MAX > 65535) begin : g_bad_poll_max
        $error("fpsb_host: POLL_MAX must be 1 to 65535");
    end
    if (RESET_ERR_CYC > 1023) begin : g_bad_reset_wait
        $error("fpsb_host: reset wait counter too narrow");
    end

    function automatic fpsb_step_t seq_step(input logic [3:0] cmd, input logic [2:0] idx);
        fpsb_step_t s;
        s = '{last: 1'b0, tgt_addr: 1'b0, tgt_data: 1'b0, addr: FL_ADDR_UNLOCK1, data: FL_UNLOCK1};
        if (idx == 3'd1 || idx == 3'd4) begin
            s.addr = FL_ADDR_UNLOCK2;
            s.data = FL_UNLOCK2;
        end
        unique case (cmd)
            CMD_PROG: begin
                if (idx == 3'd2) s.data = FL_PROGRAM;
                if (idx == 3'd3) s = '{1'b1, 1'b1, 1'b1, FL_ADDR_ANY, FL_UNLOCK1};
            end
            CMD_SERASE, CMD_BERASE: begin
                if (idx == 3'd2) s.data = FL_ERASE_SETUP;
                if (idx == 3'd5) begin
                    s.last = 1'b1;
                    s.tgt_addr = (cmd == CMD_SERASE);
                    s.data = (cmd == CMD_SERASE) ? FL_SECTOR_ERASE : FL_BULK_ERASE;
                end
            end
            CMD_BYP_ENTER: begin
                if (idx == 3'd2) s = '{1'b1, 1'b0, 1'b0, FL_ADDR_UNLOCK1, FL_BYPASS};
            end
            CMD_BYP_PROG: begin
                s = '{1'b0, 1'b0, 1'b0, FL_ADDR_ANY, FL_PROGRAM};
                if (idx == 3'd1) s = '{1'b1, 1'b1, 1'b1, FL_ADDR_ANY, FL_UNLOCK1};
            end
            CMD_BYP_EXIT: begin
                s = '{idx == 3'd1, 1'b0, 1'b0, FL_ADDR_ANY, (idx == 3'd1) ? FL_BYP_EXIT2 : FL_BYP_EXIT1};
            end
            default: s = '{1'b1, 1'b0, 1'b0, FL_ADDR_ANY, FL_RESET};
        endcase
        return s;
    endfunction

    assign step = seq_step(cmd_r, step_r);
    assign new_cmd = reg_wdata_i[CTRL_CMD_LSB +: 4];

    // Bypass mode admits only bypass program and exit; error state outside bypass admits only reset and read.
    always_comb begin
        if (bypass_r) begin
            start_ok = (new_cmd == CMD_BYP_PROG) || (new_cmd == CMD_BYP_EXIT);
        end else if (err_seen_r) begin
            start_ok = (new_cmd == CMD_RESET) || (new_cmd == CMD_READ);
        end else begin
            start_ok = (new_cmd != CMD_NOP) && (new_cmd != CMD_BYP_PROG) && (new_cmd != CMD_BYP_EXIT);
        end
    end

    // Completion test: data polling compares bit 7, toggle mode waits for two reads with equal bit 6.
    always_comb begin
        if (toggle_mode_r) begin
            poll_hit = have_prev_r && (bus_rdata[ST_TOGGLE] == prev_r[ST_TOGGLE]);
        end else if (cmd_r == CMD_PROG || cmd_r == CMD_BYP_PROG) begin
            poll_hit = (bus_rdata[ST_POLL] == tgt_data_r[ST_POLL]);
        end else begin
            poll_hit = bus_rdata[ST_POLL];
        end
    end

    assign bus_start = !pend_r && (state_r == S_WRITE || state_r == S_POLL
                                   || state_r == S_VERIFY || state_r == S_READ);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_r <= 1'b0;
        end else if (bus_start) begin
            pend_r <= 1'b1;
        end else if (bus_done) begin
            pend_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_r <= CMD_NOP;
            toggle_mode_r <= 1'b0;
            tgt_addr_r <= '0;
            tgt_data_r <= 16'h0000;
            select_r <= 12'h000;
        end else if (reg_wr_i && state_r == S_IDLE) begin
            if (reg_addr_i == REG_CTRL && start_ok) begin
                cmd_r <= new_cmd;
                toggle_mode_r <= reg_wdata_i[CTRL_TOGGLE_BIT];
            end
            if (reg_addr_i == REG_ADDR) tgt_addr_r <= reg_wdata_i[ADDR_W-1:0];
            if (reg_addr_i == REG_DATA) tgt_data_r <= reg_wdata_i[15:0];
            if (reg_addr_i == REG_SELECT) select_r <= reg_wdata_i[11:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= S_IDLE;
            step_r <= 3'd0;
            poll_cnt_r <= 16'h0000;
            wait_cnt_r <= 10'h000;
            have_prev_r <= 1'b0;
            recheck_r <= 1'b0;
            prev_r <= 16'h0000;
        end else begin
            unique case (state_r)
                S_IDLE: begin
                    step_r <= 3'd0;
                    poll_cnt_r <= 16'h0000;
                    have_prev_r <= 1'b0;
                    recheck_r <= 1'b0;
                    if (reg_wr_i && reg_addr_i == REG_CTRL && start_ok) begin
                        state_r <= (new_cmd == CMD_READ) ? S_READ : S_WRITE;
                    end
                end
                S_WRITE: begin
                    if (bus_done) begin
                        step_r <= step_r + 3'd1;
                        if (step.last) begin
                            // Polling starts only after the final write of the sequence.
                            if (cmd_r == CMD_RESET) begin
                                state_r <= err_seen_r ? S_WAIT : S_IDLE;
                                wait_cnt_r <= 10'(RESET_ERR_CYC);
                            end else if (cmd_r == CMD_BYP_ENTER || cmd_r == CMD_BYP_EXIT) begin
                                state_r <= S_IDLE;
                            end else begin
                                state_r <= S_POLL;
                            end
                        end
                    end
                end
                S_POLL: begin
                    if (bus_done) begin
                        prev_r <= bus_rdata;
                        have_prev_r <= 1'b1;
                        poll_cnt_r <= poll_cnt_r + 16'h0001;
                        if (poll_hit && !(toggle_mode_r && bus_rdata[ST_ERROR] && !recheck_r)) begin
                            state_r <= (cmd_r == CMD_PROG || cmd_r == CMD_BYP_PROG) ? S_VERIFY : S_IDLE;
                        end else if (recheck_r || poll_cnt_r == 16'(POLL_MAX - 1)) begin
                            state_r <= S_IDLE;
                        end else if (bus_rdata[ST_ERROR]) begin
                            recheck_r <= 1'b1;
                        end
                    end
                end
                S_VERIFY, S_READ: begin
                    if (bus_done) state_r <= S_IDLE;
                end
                S_WAIT: begin
                    wait_cnt_r <= wait_cnt_r - 10'h001;
                    if (wait_cnt_r == 10'h001) state_r <= S_IDLE;
                end
            endcase
        end
    end

    // Outcome flags; an idle control write clears done_r, fail_r, verify_err_r, tmo_r; all but busy_r and refused_r are set only while the order runs.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
            fail_r <= 1'b0;
            verify_err_r <= 1'b0;
            refused_r <= 1'b0;
            tmo_r <= 1'b0;
            bypass_r <= 1'b0;
            err_seen_r <= 1'b0;
            last_rd_r <= 16'h0000;
        end else begin
            if (reg_wr_i && reg_addr_i == REG_CTRL && state_r == S_IDLE) begin
                busy_r <= start_ok;
                done_r <= 1'b0;
                fail_r <= 1'b0;
                verify_err_r <= 1'b0;
                tmo_r <= 1'b0;
                refused_r <= !start_ok;
            end else if (state_r != S_IDLE && (bus_done || state_r == S_WAIT)) begin
                if (state_r != S_WRITE) last_rd_r <= bus_rdata;
                if (state_r == S_POLL && !(poll_hit && !(toggle_mode_r && bus_rdata[ST_ERROR] && !recheck_r))
                    && (recheck_r || poll_cnt_r == 16'(POLL_MAX - 1))) begin
                    busy_r <= 1'b0;
                    fail_r <= 1'b1;
                    tmo_r <= !recheck_r;
                    err_seen_r <= recheck_r;
                end else if (state_r == S_VERIFY) begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                    verify_err_r <= (bus_rdata != tgt_data_r);
                end else if ((state_r == S_WRITE && step.last && !(cmd_r == CMD_RESET && err_seen_r)
                              && cmd_r != CMD_PROG && cmd_r != CMD_BYP_PROG && cmd_r != CMD_SERASE
                              && cmd_r != CMD_BERASE)
                             || (state_r == S_WAIT && wait_cnt_r == 10'h001)
                             || state_r == S_READ
                             || (state_r == S_POLL && poll_hit && !(toggle_mode_r && bus_rdata[ST_ERROR] && !recheck_r)
                                 && cmd_r != CMD_PROG && cmd_r != CMD_BYP_PROG)) begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                    if (state_r == S_WRITE && cmd_r == CMD_BYP_ENTER) bypass_r <= 1'b1;
                    if (state_r == S_WRITE && cmd_r == CMD_BYP_EXIT) bypass_r <= 1'b0;
                    if (cmd_r == CMD_RESET) err_seen_r <= 1'b0;
                end
            end
        end
    end

    // Register read data stand in the cycle after the read strobe.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                REG_CTRL: reg_rdata_o <= {27'h0, toggle_mode_r, cmd_r};
                REG_ADDR: reg_rdata_o <= 32'(tgt_addr_r);
                REG_DATA: reg_rdata_o <= {16'h0, tgt_data_r};
                REG_SELECT: reg_rdata_o <= {20'h0, select_r};
                REG_STATUS: reg_rdata_o <= {16'h0, last_rd_r[ST_POLL], last_rd_r[ST_TOGGLE],
                                            last_rd_r[ST_ERROR], last_rd_r[ST_ERASE_TMO], 4'h0,
                                            err_seen_r, bypass_r, tmo_r, refused_r,
                                            verify_err_r, fail_r, done_r, busy_r};
                REG_RDATA: reg_rdata_o <= {16'h0, last_rd_r};
                default: reg_rdata_o <= 32'h0000_0000;
            endcase
        end
    end

    fpsb_bus #(
        .ADDR_W(ADDR_W)
    ) u_bus (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(bus_start),
        .write_i(state_r == S_WRITE),
        // Status and verify reads go to the target address with bit 0 cleared.
        .addr_i((state_r == S_WRITE && !step.tgt_addr) ? ADDR_W'(step.addr) : {tgt_addr_r[ADDR_W-1:1], 1'b0}),
        .wdata_i(step.tgt_data ? tgt_data_r : {8'h00, step.data}),
        .sel_i(select_r),
        .done_o(bus_done),
        .rdata_o(bus_rdata),
        .flash_addr_o(flash_addr_o),
        .flash_dq_o(flash_dq_o),
        .flash_dq_oe_o(flash_dq_oe_o),
        .flash_dq_i(flash_dq_i),
        .flash_wr_n_o(flash_wr_n_o),
        .flash_rd_n_o(flash_rd_n_o),
        .main_sector_select_o(main_sector_select_o),
        .boot_sector_select_o(boot_sector_select_o)
    );
endmodule // fpsb_host

// ### hdl/fpsb_pkg.sv
package fpsb_pkg;
    // Software register byte offsets.
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_ADDR = 5'h04;
    localparam logic [4:0] REG_DATA = 5'h08;
    localparam logic [4:0] REG_SELECT = 5'h0C;
    localparam logic [4:0] REG_STATUS = 5'h10;
    localparam logic [4:0] REG_RDATA = 5'h14;
    // Control register fields.
    localparam int CTRL_CMD_LSB = 0;
    localparam int CTRL_TOGGLE_BIT = 4;
    // Orders written into the control register.
    localparam logic [3:0] CMD_NOP = 4'h0;
    localparam logic [3:0] CMD_READ = 4'h1;
    localparam logic [3:0] CMD_PROG = 4'h2;
    localparam logic [3:0] CMD_SERASE = 4'h3;
    localparam logic [3:0] CMD_BERASE = 4'h4;
    localparam logic [3:0] CMD_BYP_ENTER = 4'h5;
    localparam logic [3:0] CMD_BYP_PROG = 4'h6;
    localparam logic [3:0] CMD_BYP_EXIT = 4'h7;
    localparam logic [3:0] CMD_RESET = 4'h8;
    // Flash instruction bytes and decode addresses.
    localparam logic [7:0] FL_UNLOCK1 = 8'hAA;
    localparam logic [7:0] FL_UNLOCK2 = 8'h55;
    localparam logic [7:0] FL_ERASE_SETUP = 8'h80;
    localparam logic [7:0] FL_SECTOR_ERASE = 8'h30;
    localparam logic [7:0] FL_BULK_ERASE = 8'h10;
    localparam logic [7:0] FL_PROGRAM = 8'hA0;
    localparam logic [7:0] FL_BYPASS = 8'h20;
    localparam logic [7:0] FL_BYP_EXIT1 = 8'h90;
    localparam logic [7:0] FL_BYP_EXIT2 = 8'h00;
    localparam logic [7:0] FL_RESET = 8'hF0;
    localparam logic [11:0] FL_ADDR_UNLOCK1 = 12'hAAA;
    localparam logic [11:0] FL_ADDR_UNLOCK2 = 12'h554;
    localparam logic [11:0] FL_ADDR_ANY = 12'h000;
    // Status bit positions in the read word.
    localparam int ST_POLL = 7;
    localparam int ST_TOGGLE = 6;
    localparam int ST_ERROR = 5;
    localparam int ST_ERASE_TMO = 3;
    // Timing.
    localparam int CLK_MHZ = 20;
    localparam int T_STROBE_NS = 100;
    localparam int STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int SYNC_CYC = 2;
    localparam int T_RESET_ERR_US = 25;
    localparam int RESET_ERR_CYC = T_RESET_ERR_US * CLK_MHZ;
    localparam int POLL_MAX_DEF = 4000;
    // One write of an instruction sequence.
    typedef struct packed {
        logic last;
        logic tgt_addr;
        logic tgt_data;
        logic [11:0] addr;
        logic [7:0] data;
    } fpsb_step_t;
endpackage
